// >>> audio_routing_consts.vh
// Constants for the audio output routing register and its serial port
`ifndef AUDIO_ROUTING_CONSTS_VH
`define AUDIO_ROUTING_CONSTS_VH

// ----------------------------------------------------------------
// Register location
// ----------------------------------------------------------------
`define ROUTING_REG_OFFSET     6'h20
`define ROUTING_REG_PAGE       4'h2
`define ROUTING_REG_RESET      16'h0006

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DIFF_SEL_BIT           15
`define DAC_PRI_HI             14
`define DAC_PRI_LO             13
`define AST_PRI_BIT            12
`define BUZ_PRI_BIT            11
`define KCL_PRI_BIT            10
`define CPI_PRI_BIT            9
`define DAC_SEC_HI             8
`define DAC_SEC_LO             7
`define AST_SEC_BIT            6
`define BUZ_SEC_BIT            5
`define KCL_SEC_BIT            4
`define CPI_SEC_BIT            3
`define MUTE_PRI_BIT           2
`define MUTE_SEC_BIT           1
`define HP_PROT_BIT            0

// ----------------------------------------------------------------
// Command word layout
// ----------------------------------------------------------------
`define CMD_READ_BIT           15
`define CMD_PAGE_HI            14
`define CMD_PAGE_LO            11
`define CMD_ADDR_HI            10
`define CMD_ADDR_LO            5

// ----------------------------------------------------------------
// Frame bit counts
// ----------------------------------------------------------------
`define CMD_LAST_BIT           6'h0F
`define DATA_FIRST_BIT         6'h10
`define FRAME_LAST_BIT         6'h1F
`define FRAME_BITS             6'h20

`endif

// >>> serial_frame_slave.v
// Oversampled serial control port slave: 16-bit command then 16-bit data
`timescale 1ns/10ps
`include "audio_routing_consts.vh"

module serial_frame_slave (
    // Clock and reset
    input  wire        clock,
    input  wire        reset,
    input  wire        ce,
    // Serial pins
    input  wire        sclk_pin,
    input  wire        cs_n_pin,
    input  wire        mosi_pin,
    output reg         miso,
    output reg         miso_oe_n,
    // Word side
    input  wire [15:0] rd_word,
    output reg  [15:0] cmd_word,
    output reg         cmd_strobe,
    output reg  [15:0] wr_word,
    output reg         wr_strobe
);

    reg [1:0]  sclk_s_q;
    reg [1:0]  cs_n_s_q;
    reg [1:0]  mosi_s_q;
    reg        sclk_prev_q;
    reg [5:0]  bit_cnt_q;
    reg [15:0] rx_q;
    reg [15:0] tx_q;
    reg        load_q;

    wire       sclk_rise = sclk_s_q[1] & ~sclk_prev_q;
    wire       sclk_fall = ~sclk_s_q[1] & sclk_prev_q;
    wire       active    = ~cs_n_s_q[1];
    wire [15:0] rx_next  = {rx_q[14:0], mosi_s_q[1]};

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            sclk_s_q    <= 2'h0;
            cs_n_s_q    <= 2'h3;
            mosi_s_q    <= 2'h0;
            sclk_prev_q <= 1'b0;
            bit_cnt_q   <= 6'h00;
            rx_q        <= 16'h0000;
            tx_q        <= 16'h0000;
            load_q      <= 1'b0;
            cmd_word    <= 16'h0000;
            cmd_strobe  <= 1'b0;
            wr_word     <= 16'h0000;
            wr_strobe   <= 1'b0;
            miso        <= 1'b0;
            miso_oe_n   <= 1'b1;
        end else if (ce) begin
            sclk_s_q    <= {sclk_s_q[0], sclk_pin};
            cs_n_s_q    <= {cs_n_s_q[0], cs_n_pin};
            mosi_s_q    <= {mosi_s_q[0], mosi_pin};
            sclk_prev_q <= sclk_s_q[1];
            cmd_strobe  <= 1'b0;
            wr_strobe   <= 1'b0;
            load_q      <= cmd_strobe;
            // Read data is sampled one cycle after the command is decoded
            if (load_q) begin
                tx_q <= rd_word;
            end
            if (!active) begin
                bit_cnt_q <= 6'h00;
                miso      <= 1'b0;
                miso_oe_n <= 1'b1;
            end else begin
                miso_oe_n <= 1'b0;
                if (sclk_rise && bit_cnt_q < `FRAME_BITS) begin
                    rx_q      <= rx_next;
                    bit_cnt_q <= bit_cnt_q + 6'h01;
                    if (bit_cnt_q == `CMD_LAST_BIT) begin
                        cmd_word   <= rx_next;
                        cmd_strobe <= 1'b1;
                    end
                    if (bit_cnt_q == `FRAME_LAST_BIT) begin
                        wr_word   <= rx_next;
                        wr_strobe <= 1'b1;
                    end
                end
                // Data phase shifts out MSB first on falling edges
                if (sclk_fall && bit_cnt_q >= `DATA_FIRST_BIT && bit_cnt_q < `FRAME_BITS) begin
                    miso <= tx_q[15];
                    tx_q <= {tx_q[14:0], 1'b0};
                end
            end
        end
    end

endmodule

// >>> audio_output_routing_regs.v
// Audio output routing control register with serial port and driver gating
`timescale 1ns/10ps
`include "audio_routing_consts.vh"

module audio_output_routing_regs (
    // Clock and reset
    input  wire       clock,
    input  wire       reset,
    input  wire       ce,
    // Serial control port
    input  wire       sclk_pin,
    input  wire       cs_n_pin,
    input  wire       mosi_pin,
    output wire       miso,
    output wire       miso_oe_n,
    // Driver power requests from the power control registers
    input  wire       primary_power_request,
    input  wire       earpiece_power_request,
    // Driver enables after automatic power-down, and the secondary power request
    output reg        primary_speaker_driver_en,
    output reg        inverting_earpiece_driver_en,
    output reg        secondary_speaker_driver_en,
    input  wire       secondary_power_request,
    // Mode
    output reg        differential_output_select,
    // Primary path routing
    output reg  [1:0] dac_to_primary_route,
    output reg        sidetone_to_primary_route,
    output reg        buzzer_to_primary_route,
    output reg        keyclick_to_primary_route,
    output reg        cellin_to_primary_route,
    output reg        primary_path_mute,
    // Secondary driver routing, forced off in differential mode
    output reg  [1:0] dac_to_secondary_route,
    output reg        sidetone_to_secondary_route,
    output reg        buzzer_to_secondary_route,
    output reg        keyclick_to_secondary_route,
    output reg        cellin_to_secondary_route,
    output reg        secondary_driver_mute,
    // Protection
    output reg        headphone_short_protect_disable
);

    // ----------------------------------------------------------------
    // Serial port
    // ----------------------------------------------------------------
    wire [15:0] cmd_word;
    wire        cmd_strobe;
    wire [15:0] wr_word;
    wire        wr_strobe;
    reg  [15:0] rd_word_q;
    reg         cmd_hit_q;
    reg         cmd_read_q;

    serial_frame_slave u_port (
        .clock      (clock),
        .reset      (reset),
        .ce         (ce),
        .sclk_pin   (sclk_pin),
        .cs_n_pin   (cs_n_pin),
        .mosi_pin   (mosi_pin),
        .miso       (miso),
        .miso_oe_n  (miso_oe_n),
        .rd_word    (rd_word_q),
        .cmd_word   (cmd_word),
        .cmd_strobe (cmd_strobe),
        .wr_word    (wr_word),
        .wr_strobe  (wr_strobe)
    );

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    reg  [15:0] ctrl_q;
    wire [3:0]  cmd_page = cmd_word[`CMD_PAGE_HI:`CMD_PAGE_LO];
    wire [5:0]  cmd_addr = cmd_word[`CMD_ADDR_HI:`CMD_ADDR_LO];
    reg         cmd_match;
    reg  [15:0] rd_word_d;

    // Bits below the address field are ignored
    // Unmapped reads return zero; the write-only bit always reads zero
    always @* begin
        cmd_match = 1'b0;
        rd_word_d = 16'h0000;
        if (cmd_page != `ROUTING_REG_PAGE) begin
            cmd_match = 1'b0;
        end else if (cmd_addr == `ROUTING_REG_OFFSET) begin
            cmd_match = 1'b1;
            rd_word_d = {ctrl_q[15:1], 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    wire        write_hit = wr_strobe && cmd_hit_q && !cmd_read_q;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_q     <= `ROUTING_REG_RESET;
            cmd_hit_q  <= 1'b0;
            cmd_read_q <= 1'b0;
            rd_word_q  <= 16'h0000;
        end else if (ce) begin
            // Target and direction are held for the data half of the frame
            if (cmd_strobe) begin
                cmd_hit_q  <= cmd_match;
                cmd_read_q <= cmd_word[`CMD_READ_BIT];
                rd_word_q  <= rd_word_d;
            end
            if (write_hit) begin
                ctrl_q <= wr_word;
            end
        end
    end

    // ----------------------------------------------------------------
    // Driver power gating
    // ----------------------------------------------------------------
    wire diff_mode      = ctrl_q[`DIFF_SEL_BIT];
    wire pair_ok        = primary_power_request & earpiece_power_request;
    wire pair_en        = ~diff_mode | pair_ok;
    wire primary_en_d   = primary_power_request & pair_en;
    wire earpiece_en_d  = earpiece_power_request & pair_en;
    // The secondary driver takes no part in the differential pair
    wire secondary_en_d = secondary_power_request & ~diff_mode;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            primary_speaker_driver_en    <= 1'b0;
            inverting_earpiece_driver_en <= 1'b0;
            secondary_speaker_driver_en  <= 1'b0;
        end else if (ce) begin
            primary_speaker_driver_en    <= primary_en_d;
            inverting_earpiece_driver_en <= earpiece_en_d;
            secondary_speaker_driver_en  <= secondary_en_d;
        end
    end

    // ----------------------------------------------------------------
    // Secondary routing, single-ended only
    // ----------------------------------------------------------------
    reg  [1:0]  dac_secondary_d;
    reg         sidetone_secondary_d;
    reg         buzzer_secondary_d;
    reg         keyclick_secondary_d;
    reg         cellin_secondary_d;
    reg         secondary_mute_d;

    // Differential mode parks the secondary driver silent and muted
    always @* begin
        dac_secondary_d      = ctrl_q[`DAC_SEC_HI:`DAC_SEC_LO];
        sidetone_secondary_d = ctrl_q[`AST_SEC_BIT];
        buzzer_secondary_d   = ctrl_q[`BUZ_SEC_BIT];
        keyclick_secondary_d = ctrl_q[`KCL_SEC_BIT];
        cellin_secondary_d   = ctrl_q[`CPI_SEC_BIT];
        secondary_mute_d     = ctrl_q[`MUTE_SEC_BIT];
        // Forced values win over the stored fields
        if (diff_mode) begin
            dac_secondary_d      = 2'h0;
            sidetone_secondary_d = 1'b0;
            buzzer_secondary_d   = 1'b0;
            keyclick_secondary_d = 1'b0;
            cellin_secondary_d   = 1'b0;
            secondary_mute_d     = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Routing outputs
    // ----------------------------------------------------------------
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            differential_output_select      <= 1'b0;
            dac_to_primary_route            <= 2'h0;
            sidetone_to_primary_route       <= 1'b0;
            buzzer_to_primary_route         <= 1'b0;
            keyclick_to_primary_route       <= 1'b0;
            cellin_to_primary_route         <= 1'b0;
            primary_path_mute               <= 1'b1;
            dac_to_secondary_route          <= 2'h0;
            sidetone_to_secondary_route     <= 1'b0;
            buzzer_to_secondary_route       <= 1'b0;
            keyclick_to_secondary_route     <= 1'b0;
            cellin_to_secondary_route       <= 1'b0;
            secondary_driver_mute           <= 1'b1;
            headphone_short_protect_disable <= 1'b0;
        end else if (ce) begin
            // Primary settings act in both output modes
            differential_output_select      <= diff_mode;
            dac_to_primary_route            <= ctrl_q[`DAC_PRI_HI:`DAC_PRI_LO];
            sidetone_to_primary_route       <= ctrl_q[`AST_PRI_BIT];
            buzzer_to_primary_route         <= ctrl_q[`BUZ_PRI_BIT];
            keyclick_to_primary_route       <= ctrl_q[`KCL_PRI_BIT];
            cellin_to_primary_route         <= ctrl_q[`CPI_PRI_BIT];
            primary_path_mute               <= ctrl_q[`MUTE_PRI_BIT];
            dac_to_secondary_route          <= dac_secondary_d;
            sidetone_to_secondary_route     <= sidetone_secondary_d;
            buzzer_to_secondary_route       <= buzzer_secondary_d;
            keyclick_to_secondary_route     <= keyclick_secondary_d;
            cellin_to_secondary_route       <= cellin_secondary_d;
            secondary_driver_mute           <= secondary_mute_d;
            headphone_short_protect_disable <= ctrl_q[`HP_PROT_BIT];
        end
    end

endmodule

// >>> routing_checker.sv
// Concurrent assertions on the audio output routing register ports
`timescale 1ns/10ps
module routing_checker (
    // Clock and reset
    input wire       clock,
    input wire       reset,
    input wire       ce,
    // Serial port
    input wire       cs_n_pin,
    input wire       miso,
    input wire       miso_oe_n,
    // Driver power
    input wire       primary_power_request,
    input wire       earpiece_power_request,
    input wire       secondary_power_request,
    input wire       primary_speaker_driver_en,
    input wire       inverting_earpiece_driver_en,
    input wire       secondary_speaker_driver_en,
    // Register fields
    input wire       differential_output_select,
    input wire [1:0] dac_to_primary_route,
    input wire       primary_path_mute,
    input wire [1:0] dac_to_secondary_route,
    input wire       sidetone_to_secondary_route,
    input wire       buzzer_to_secondary_route,
    input wire       keyclick_to_secondary_route,
    input wire       cellin_to_secondary_route,
    input wire       secondary_driver_mute,
    input wire       headphone_short_protect_disable
);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    AST_RESET_VAL: assert property (disable iff (1'b0) reset |-> primary_path_mute && secondary_driver_mute
        && dac_to_primary_route == 2'h0 && !differential_output_select && !headphone_short_protect_disable)
        else $error("Outputs not at reset values");
    AST_SEC_ROUTE_OFF: assert property (differential_output_select |-> dac_to_secondary_route == 2'h0
        && !sidetone_to_secondary_route && !buzzer_to_secondary_route && !keyclick_to_secondary_route
        && !cellin_to_secondary_route) else $error("Secondary route live in differential mode");
    AST_SEC_MUTE: assert property (differential_output_select |-> secondary_driver_mute)
        else $error("Secondary driver unmuted in differential mode");
    AST_PRI_EN: assert property ($past(ce) |-> primary_speaker_driver_en == ($past(primary_power_request)
        && (!differential_output_select || $past(earpiece_power_request)))) else $error("Primary enable wrong");
    AST_EAR_EN: assert property ($past(ce) |-> inverting_earpiece_driver_en == ($past(earpiece_power_request)
        && (!differential_output_select || $past(primary_power_request)))) else $error("Earpiece enable wrong");
    AST_SEC_EN: assert property ($past(ce) |-> secondary_speaker_driver_en ==
        ($past(secondary_power_request) && !differential_output_select)) else $error("Secondary enable wrong");
    AST_HOLD: assert property (cs_n_pin [*8] |=> $stable({differential_output_select, dac_to_primary_route,
        primary_path_mute, headphone_short_protect_disable})) else $error("Fields changed outside a frame");
    AST_OE_LOW: assert property ($fell(cs_n_pin) |-> ##3 !miso_oe_n) else $error("Data out not enabled in frame");
    AST_MISO_IDLE: assert property (miso_oe_n |-> !miso) else $error("Data out not low while idle");
    cover property (differential_output_select && primary_speaker_driver_en && inverting_earpiece_driver_en);
    cover property (dac_to_primary_route == 2'h3);
    cover property (!miso_oe_n && miso);
endmodule
bind audio_output_routing_regs routing_checker chk (.*);

// >>> audio_output_routing_regs_tb.sv
// Self-checking bench for the audio output routing register block
`timescale 1ns/10ps
`include "audio_routing_consts.vh"
module audio_output_routing_regs_tb;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    reg         clock, reset, sclk_pin, cs_n_pin, mosi_pin, ce;
    reg  [2:0]  req;
    reg  [15:0] rdata, d;
    reg  [15:0] words [0:5];
    wire        miso, miso_oe_n, pri_en, ear_en, sec_en;
    wire [15:0] outs;
    integer     fails, comparisons, i, j;
    audio_output_routing_regs dut (
        .clock(clock), .reset(reset), .ce(ce),
        .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .mosi_pin(mosi_pin), .miso(miso), .miso_oe_n(miso_oe_n),
        .primary_power_request(req[2]), .earpiece_power_request(req[1]), .secondary_power_request(req[0]),
        .primary_speaker_driver_en(pri_en), .inverting_earpiece_driver_en(ear_en),
        .secondary_speaker_driver_en(sec_en), .differential_output_select(outs[15]),
        .dac_to_primary_route(outs[14:13]), .sidetone_to_primary_route(outs[12]),
        .buzzer_to_primary_route(outs[11]), .keyclick_to_primary_route(outs[10]),
        .cellin_to_primary_route(outs[9]), .dac_to_secondary_route(outs[8:7]),
        .sidetone_to_secondary_route(outs[6]), .buzzer_to_secondary_route(outs[5]),
        .keyclick_to_secondary_route(outs[4]), .cellin_to_secondary_route(outs[3]),
        .primary_path_mute(outs[2]), .secondary_driver_mute(outs[1]), .headphone_short_protect_disable(outs[0])
    );
    initial begin
        clock = 0;
        forever #2 clock = ~clock;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task check(input [15:0] got, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Sclk phases of 10 clocks; data out is sampled just before each rise of the data half
    task frame(input [31:0] w, input integer last);
        begin
            cs_n_pin = 0;
            repeat (4) @(negedge clock);
            for (i = 31; i >= last; i = i - 1) begin
                mosi_pin = w[i];
                repeat (10) @(negedge clock);
                if (i < 16) rdata[i] = miso;
                sclk_pin = 1;
                repeat (10) @(negedge clock);
                sclk_pin = 0;
            end
            repeat (10) @(negedge clock);
            cs_n_pin = 1;
            mosi_pin = ~mosi_pin;
            repeat (10) @(negedge clock);
        end
    endtask
    task wr(input [5:0] a, input [15:0] v);
        frame({1'b0, `ROUTING_REG_PAGE, a, 5'h00, v}, 0);
    endtask
    task rd(input [5:0] a);
        frame({1'b1, `ROUTING_REG_PAGE, a, 5'h00, 16'h0000}, 0);
    endtask
    task results;
        begin
            $display("comparisons=%0d fails=%0d", comparisons, fails);
            if (fails == 0 && comparisons > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        fails = fails + 1;
        results;
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        fails = 0;
        comparisons = 0;
        reset = 1;
        sclk_pin = 0;
        cs_n_pin = 1;
        mosi_pin = 0;
        ce = 1;
        req = 3'h0;
        words[0] = 16'h3E01;
        words[1] = 16'h4080;
        words[2] = 16'h6178;
        words[3] = 16'h0186;
        words[4] = 16'hFFFF;
        words[5] = 16'h8000;
        repeat (16) @(negedge clock);
        reset = 0;
        repeat (4) @(negedge clock);
        check(outs, `ROUTING_REG_RESET);
        rd(`ROUTING_REG_OFFSET);
        check(rdata, `ROUTING_REG_RESET);
        for (j = 0; j < 6; j = j + 1) begin
            d = words[j];
            wr(`ROUTING_REG_OFFSET, d);
            check(outs, d[15] ? ((d & 16'hFE07) | 16'h0002) : d);
            rd(`ROUTING_REG_OFFSET);
            check(rdata, d & 16'hFFFE);
        end
        // Every request pattern in both output modes
        for (j = 0; j < 16; j = j + 1) begin
            if (j % 8 == 0) wr(`ROUTING_REG_OFFSET, {j[3], 15'h0000});
            req = j[2:0];
            repeat (3) @(negedge clock);
            check({pri_en, ear_en, sec_en}, {j[2] & (~j[3] | j[1]), j[1] & (~j[3] | j[2]), j[0] & ~j[3]});
        end
        wr(`ROUTING_REG_OFFSET + 6'h01, 16'hFFFF);
        check(outs, 16'h8002);
        rd(`ROUTING_REG_OFFSET + 6'h01);
        check(rdata, 16'h0000);
        // A wrong page and a frame cut after 22 bits leave the register alone
        frame({1'b0, 4'h3, `ROUTING_REG_OFFSET, 5'h00, 16'hFFFF}, 0);
        frame({1'b0, `ROUTING_REG_PAGE, `ROUTING_REG_OFFSET, 5'h00, 16'hFFFF}, 10);
        check(outs, 16'h8002);
        // Unpaired requests: off in differential mode, on once single-ended
        req = 3'h4;
        repeat (3) @(negedge clock);
        check({pri_en, ear_en, sec_en}, 16'h0000);
        wr(`ROUTING_REG_OFFSET, 16'h0000);
        check({pri_en, ear_en, sec_en}, 16'h0004);
        // Clock enable low freezes the enables
        ce = 0;
        req = 3'h3;
        repeat (3) @(negedge clock);
        check({pri_en, ear_en, sec_en}, 16'h0004);
        ce = 1;
        repeat (3) @(negedge clock);
        check({pri_en, ear_en, sec_en}, 16'h0003);
        results;
    end
endmodule
